/* File: shared/rtlo_consts.svh */
// register offsets, reset values and field positions of the remote bank
// assumes inclusion by the core module only
`ifndef RTLO_CONSTS_SVH
`define RTLO_CONSTS_SVH
`define RTLO_RD_LOW_LIMIT 8'h08
`define RTLO_WR_LOW_LIMIT 8'h0e
`define RTLO_WR_ONE_SHOT 8'h0f
`define RTLO_RD_RESULT_HI 8'h01
`define RTLO_RD_RESULT_LO 8'h10
`define RTLO_OFFSET_HI 8'h11
`define RTLO_OFFSET_LO 8'h12
`define RTLO_RST_BYTE 8'h00
`define RTLO_FRAC_MSB 7
`define RTLO_FRAC_LSB 4
`define RTLO_FRAC_MASK 8'hf0
`define RTLO_EXT_BIAS 12'h400
`define RTLO_STD_MAX 12'h7f0
`define RTLO_EXT_MAX 12'hbf0
`endif

/* File: shared/rtlo_pkg.sv */
// types shared by the remote limit and offset register bank
// assumes no surroundings
package rtlo_pkg;
    typedef enum logic [2:0] {
        RTLO_RUN = 3'b001,
        RTLO_STOP = 3'b010,
        RTLO_SHOT = 3'b100
    } rtlo_mode_t;
    typedef enum logic [2:0] {
        RTLO_FREE = 3'b001,
        RTLO_HOLD_LO = 3'b010,
        RTLO_HOLD_HI = 3'b100
    } rtlo_lock_t;
endpackage

/* File: core/rtlo_regs.sv */
// remote low limit, one-shot, result and offset register bank
// assumes a serial front end giving one-cycle read/write pointer strobes
// and a conversion engine pulsing i_conv_done with a signed 12-bit sample
//
// Behaviour
// - low limit upper byte, separate read/write pointers
// - compare each finished result with low limit
// - one-shot write in shutdown starts one conversion
// - result fraction in bits seven to four
// - result low byte updated unless locked
// - upper byte read first locks low byte
// - low byte read first locks upper byte
// - reading other register releases the lock
// - offset added to every remote conversion
// - offset uses result format, may be negative
// - offset upper byte is integer degrees
// - offset low byte holds four fraction bits
// - shutdown stops after current conversion
// - range bit selects standard or extended format
`timescale 1ns/1ps
`include "rtlo_consts.svh"
module rtlo_regs
    import rtlo_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic [7:0] i_wr_ptr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd,
    input wire logic [7:0] i_rd_ptr,
    output logic [7:0] o_rd_data,
    input wire logic i_shutdown_control,
    input wire logic i_range_ext,
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_raw,
    output logic o_conv_start,
    output logic o_converting,
    output logic [7:0] o_result_upper,
    output logic o_below_low_limit
);
    logic [7:0] limit_hi, next_limit_hi;
    logic [7:0] ofs_hi, next_ofs_hi;
    logic [3:0] ofs_lo, next_ofs_lo;
    logic [7:0] res_hi, next_res_hi;
    logic [3:0] res_lo, next_res_lo;
    logic [7:0] rd_data, next_rd_data;
    logic below, next_below;
    logic start, next_start;
    rtlo_mode_t mode, next_mode;
    rtlo_lock_t lock, next_lock;
    logic signed [12:0] sum;
    logic signed [12:0] bias;
    logic [11:0] stored;
    logic rd_hi_first, rd_lo_first;

    // extended format bias as a signed term
    assign bias = $signed({1'b0, `RTLO_EXT_BIAS});
    // a first-half read in an update cycle freezes the other half as well
    assign rd_hi_first = i_rd && i_rd_ptr == `RTLO_RD_RESULT_HI &&
                         lock != RTLO_HOLD_HI;
    assign rd_lo_first = i_rd && i_rd_ptr == `RTLO_RD_RESULT_LO &&
                         lock != RTLO_HOLD_LO;

    // offset in result format, sign-extended and added
    always_comb begin
        sum = $signed({i_conv_raw[11], i_conv_raw}) +
              $signed({ofs_hi[7], ofs_hi, ofs_lo});
        stored = sum[11:0];
        if (i_range_ext) begin
            if (sum < -bias)
                stored = 12'h000;
            else if (sum > $signed({1'b0, `RTLO_EXT_MAX}) - bias)
                stored = `RTLO_EXT_MAX;
            else
                stored = 12'(sum + bias);
        end else begin
            if (sum < 0)
                stored = 12'h000;
            else if (sum > $signed({1'b0, `RTLO_STD_MAX}))
                stored = `RTLO_STD_MAX;
        end
    end

    always_comb begin
        next_limit_hi = limit_hi;
        next_ofs_hi = ofs_hi;
        next_ofs_lo = ofs_lo;
        next_res_hi = res_hi;
        next_res_lo = res_lo;
        next_rd_data = rd_data;
        next_below = below;
        next_lock = lock;
        if (i_wr) begin
            unique case (i_wr_ptr)
                `RTLO_WR_LOW_LIMIT: next_limit_hi = i_wr_data;
                `RTLO_OFFSET_HI: next_ofs_hi = i_wr_data;
                `RTLO_OFFSET_LO: next_ofs_lo =
                    i_wr_data[`RTLO_FRAC_MSB:`RTLO_FRAC_LSB];
                default: ;
            endcase
        end
        if (i_conv_done) begin
            if (lock != RTLO_HOLD_HI && !rd_lo_first)
                next_res_hi = stored[11:4];
            if (lock != RTLO_HOLD_LO && !rd_hi_first)
                next_res_lo = stored[3:0];
            next_below = stored[11:4] < limit_hi;
        end
        if (i_rd) begin
            unique case (i_rd_ptr)
                `RTLO_RD_LOW_LIMIT: next_rd_data = limit_hi;
                `RTLO_RD_RESULT_HI: next_rd_data = res_hi;
                `RTLO_RD_RESULT_LO:
                    next_rd_data = {res_lo, 4'h0};
                `RTLO_OFFSET_HI: next_rd_data = ofs_hi;
                `RTLO_OFFSET_LO: next_rd_data = {ofs_lo, 4'h0};
                default: next_rd_data = `RTLO_RST_BYTE;
            endcase
            if (i_rd_ptr == `RTLO_RD_RESULT_HI)
                next_lock = (lock == RTLO_HOLD_HI) ? RTLO_FREE
                                                   : RTLO_HOLD_LO;
            else if (i_rd_ptr == `RTLO_RD_RESULT_LO)
                next_lock = (lock == RTLO_HOLD_LO) ? RTLO_FREE
                                                   : RTLO_HOLD_HI;
            else
                next_lock = RTLO_FREE;
        end
    end

    // conversion sequencing
    always_comb begin
        next_mode = mode;
        next_start = 1'b0;
        unique case (mode)
            RTLO_RUN: begin
                if (i_conv_done && i_shutdown_control)
                    next_mode = RTLO_STOP;
                else if (i_conv_done)
                    next_start = 1'b1;
            end
            RTLO_STOP: begin
                if (!i_shutdown_control) begin
                    next_mode = RTLO_RUN;
                    next_start = 1'b1;
                end else if (i_wr && i_wr_ptr == `RTLO_WR_ONE_SHOT) begin
                    next_mode = RTLO_SHOT;
                    next_start = 1'b1;
                end
            end
            RTLO_SHOT: begin
                if (i_conv_done)
                    next_mode = i_shutdown_control ? RTLO_STOP : RTLO_RUN;
                if (i_conv_done && !i_shutdown_control)
                    next_start = 1'b1;
            end
            default: next_mode = RTLO_STOP;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            limit_hi <= `RTLO_RST_BYTE;
            ofs_hi <= `RTLO_RST_BYTE;
            ofs_lo <= 4'h0;
            res_hi <= `RTLO_RST_BYTE;
            res_lo <= 4'h0;
            rd_data <= `RTLO_RST_BYTE;
            below <= 1'b0;
            lock <= RTLO_FREE;
            mode <= RTLO_STOP;
            start <= 1'b0;
        end else begin
            limit_hi <= next_limit_hi;
            ofs_hi <= next_ofs_hi;
            ofs_lo <= next_ofs_lo;
            res_hi <= next_res_hi;
            res_lo <= next_res_lo;
            rd_data <= next_rd_data;
            below <= next_below;
            lock <= next_lock;
            mode <= next_mode;
            start <= next_start;
        end
    end

    assign o_rd_data = rd_data;
    assign o_conv_start = start;
    assign o_converting = (mode != RTLO_STOP);
    assign o_result_upper = res_hi;
    assign o_below_low_limit = below;

    // checks
    property p_shot;
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode == RTLO_STOP && i_shutdown_control && i_wr &&
         i_wr_ptr == `RTLO_WR_ONE_SHOT) |=> o_conv_start;
    endproperty
    a_shot: assert property (p_shot) else $error("one-shot missed");
    property p_no_shot_run;
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode == RTLO_SHOT && !i_conv_done) |=> !o_conv_start;
    endproperty
    a_no_shot_run: assert property (p_no_shot_run)
        else $error("extra start");
    property p_sd_stop;
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode == RTLO_RUN && i_conv_done && i_shutdown_control) |=>
            (!o_converting && !o_conv_start);
    endproperty
    a_sd_stop: assert property (p_sd_stop)
        else $error("no stop after conversion in shutdown");
    property p_lo_locked;
        @(posedge i_sys_clk) disable iff (i_rst)
        (lock == RTLO_HOLD_LO && !i_rd) |=> $stable(res_lo);
    endproperty
    a_lo_locked: assert property (p_lo_locked)
        else $error("low byte changed while locked");
    property p_pair_lo;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_conv_done && rd_hi_first) |=> $stable(res_lo);
    endproperty
    a_pair_lo: assert property (p_pair_lo)
        else $error("low byte changed in upper byte read cycle");
    property p_hi_locked;
        @(posedge i_sys_clk) disable iff (i_rst)
        (lock == RTLO_HOLD_HI && !i_rd) |=> $stable(res_hi);
    endproperty
    a_hi_locked: assert property (p_hi_locked)
        else $error("upper byte changed while locked");
    property p_pair_hi;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_conv_done && rd_lo_first) |=> $stable(res_hi);
    endproperty
    a_pair_hi: assert property (p_pair_hi)
        else $error("upper byte changed in low byte read cycle");
    property p_release;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && i_rd_ptr != `RTLO_RD_RESULT_HI &&
         i_rd_ptr != `RTLO_RD_RESULT_LO) |=> lock == RTLO_FREE;
    endproperty
    a_release: assert property (p_release)
        else $error("lock not released");
    property p_update;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_conv_done && lock == RTLO_FREE && !rd_hi_first) |=>
            res_lo == $past(stored[3:0]);
    endproperty
    a_update: assert property (p_update)
        else $error("result not updated");
    property p_nibble;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && i_rd_ptr != `RTLO_OFFSET_HI &&
         i_rd_ptr != `RTLO_RD_LOW_LIMIT &&
         i_rd_ptr != `RTLO_RD_RESULT_HI) |=> o_rd_data[3:0] == 4'h0;
    endproperty
    a_nibble: assert property (p_nibble)
        else $error("low nibble not zero");
    property p_lo_rd;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && i_rd_ptr == `RTLO_RD_RESULT_LO) |=>
            o_rd_data == {$past(res_lo), 4'h0};
    endproperty
    a_lo_rd: assert property (p_lo_rd)
        else $error("result fraction read wrong");
    property p_limit_rd;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && i_rd_ptr == `RTLO_RD_LOW_LIMIT) |=>
            o_rd_data == $past(limit_hi);
    endproperty
    a_limit_rd: assert property (p_limit_rd)
        else $error("limit read wrong");
    property p_limit_wr;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_wr && i_wr_ptr == `RTLO_WR_LOW_LIMIT) |=>
            limit_hi == $past(i_wr_data);
    endproperty
    a_limit_wr: assert property (p_limit_wr)
        else $error("limit write lost");
    property p_ofs_wr;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_wr && i_wr_ptr == `RTLO_OFFSET_LO) |=>
            ofs_lo == $past(i_wr_data[7:4]);
    endproperty
    a_ofs_wr: assert property (p_ofs_wr)
        else $error("offset fraction write lost");
    property p_compare;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_conv_done |=> o_below_low_limit == ($past(stored[11:4]) <
                                               $past(limit_hi));
    endproperty
    a_compare: assert property (p_compare)
        else $error("compare wrong");
    property p_std_clamp;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_conv_done && !i_range_ext && lock != RTLO_HOLD_HI &&
         !rd_lo_first) |=> {res_hi, 4'h0} <= `RTLO_STD_MAX;
    endproperty
    a_std_clamp: assert property (p_std_clamp)
        else $error("standard range exceeded");
    c_shot: cover property (@(posedge i_sys_clk) mode == RTLO_SHOT);
    c_lock_hi: cover property (@(posedge i_sys_clk) lock == RTLO_HOLD_HI);
    c_lock_lo: cover property (@(posedge i_sys_clk)
        lock == RTLO_HOLD_LO ##1 lock == RTLO_FREE);
    c_below: cover property (@(posedge i_sys_clk) o_below_low_limit);
endmodule // rtlo_regs

/* File: sim/rtlo_conv_model.sv */
// conversion engine model facing the remote register bank
// assumes one clock shared with the bank, start pulses one cycle
`timescale 1ns/1ps
module rtlo_conv_model #(
    parameter int DELAY = 5
) (
    input wire logic i_sys_clk,
    input wire logic i_start,
    input wire logic [11:0] i_sample,
    output logic o_done,
    output logic [11:0] o_raw
);
    int cnt = 0;
    initial begin
        o_done = 1'b0;
        o_raw = 12'h000;
    end
    // sample shown only with done, a toggling pattern otherwise
    always @(posedge i_sys_clk) begin
        o_done <= 1'b0;
        o_raw <= ~o_raw;
        if (i_start) begin
            cnt <= DELAY;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_done <= 1'b1;
            o_raw <= i_sample;
        end
    end
endmodule // rtlo_conv_model

/* File: sim/test_rtlo_regs.sv */
// self-checking bench for the remote limit and offset register bank
// assumes the conversion engine model in rtlo_conv_model
`timescale 1ns/1ps
module test_rtlo_regs;
    logic clk, rst, wr, rd, sd, ext, done, start, conv, below;
    logic [7:0] wptr, wdat, rptr, rdat, upper;
    logic [11:0] raw, sample;
    int fail_count = 0, cmp_count = 0, starts = 0, cyc = 0, s1;
    rtlo_regs u_dut (.i_sys_clk(clk), .i_rst(rst), .i_wr(wr),
        .i_wr_ptr(wptr), .i_wr_data(wdat), .i_rd(rd), .i_rd_ptr(rptr),
        .o_rd_data(rdat), .i_shutdown_control(sd), .i_range_ext(ext),
        .i_conv_done(done), .i_conv_raw(raw), .o_conv_start(start),
        .o_converting(conv), .o_result_upper(upper),
        .o_below_low_limit(below));
    rtlo_conv_model u_eng (.i_sys_clk(clk), .i_start(start),
        .i_sample(sample), .o_done(done), .o_raw(raw));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (start) starts <= starts + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrb(input logic [7:0] p, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        wptr <= p;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdb(input logic [7:0] p, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        rptr <= p;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    task automatic cv(input logic [11:0] s);
        sample = s;
        wrb(8'h0f, 8'ha5);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 50 && conv; i++) @(posedge clk);
        #1;
    endtask
    initial begin
        {wr, rd, ext, wptr, wdat, rptr} = '0;
        rst = 1'b1;
        sd = 1'b1;
        sample = 12'h000;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk(starts[7:0], 8'h00);
        rdb(8'h08, 8'h00);
        rdb(8'h10, 8'h00);
        rdb(8'h11, 8'h00);
        rdb(8'h12, 8'h00);
        wrb(8'h0e, 8'h1a);
        wrb(8'h08, 8'h55);
        rdb(8'h08, 8'h1a);
        wrb(8'h11, 8'h02);
        wrb(8'h12, 8'h3f);
        rdb(8'h12, 8'h30);
        rdb(8'h11, 8'h02);
        s1 = starts;
        cv(12'h19a);
        chk(8'(starts - s1), 8'h01);
        chk(upper, 8'h1b);
        chk({7'h0, below}, 8'h00);
        rdb(8'h10, 8'hd0);
        cv(12'h2a0);
        chk(upper, 8'h1b);
        rdb(8'h01, 8'h1b);
        rdb(8'h08, 8'h1a);
        cv(12'h2a0);
        chk(upper, 8'h2c);
        rdb(8'h01, 8'h2c);
        cv(12'h19a);
        rdb(8'h10, 8'h30);
        rdb(8'h08, 8'h1a);
        wrb(8'h11, 8'hff);
        wrb(8'h12, 8'h80);
        cv(12'h19a);
        chk(upper, 8'h19);
        chk({7'h0, below}, 8'h01);
        rdb(8'h10, 8'h20);
        rdb(8'h08, 8'h1a);
        rdb(8'h01, 8'h19);
        rdb(8'h08, 8'h1a);
        cv(12'h2a5);
        chk(upper, 8'h29);
        chk({7'h0, below}, 8'h00);
        rdb(8'h10, 8'hd0);
        rdb(8'h11, 8'hff);
        wrb(8'h11, 8'h00);
        wrb(8'h12, 8'h00);
        ext <= 1'b1;
        cv(12'h19a);
        chk(upper, 8'h59);
        rdb(8'h10, 8'ha0);
        s1 = starts;
        @(posedge clk);
        sd <= 1'b0;
        repeat (40) @(posedge clk);
        #1 chk({7'h0, starts > s1 + 2}, 8'h01);
        @(posedge clk);
        sd <= 1'b1;
        repeat (20) @(posedge clk);
        s1 = starts;
        repeat (40) @(posedge clk);
        #1 chk(8'(starts - s1), 8'h00);
        chk({7'h0, conv}, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdb(8'h08, 8'h00);
        chk(upper, 8'h00);
        report_and_stop();
    end
endmodule // test_rtlo_regs
